//--- bench/data_space_byte_word_access_bench.sv
// bench: table of x datapath accesses, then mac fetches and reset
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h seen %h", n, e, s); end end
module data_space_byte_word_access_bench;
    import dsa_pkg::*;
    typedef struct {logic rd, wr; dsa_size_t sz; logic [15:0] a, d; logic dsp;
                    logic [15:0] er, ep;} dsa_row_t;
    logic        sys_clk, rstn, x_rd, x_wr, x_postinc, x_dsp, y_rd, mac_op;
    dsa_size_t   x_size;
    dsa_ptr_t    x_mac_ptr, y_mac_ptr;
    logic [15:0] x_addr, x_wdata, y_addr, x_rdata, x_next_ptr, y_rdata;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cyc = 0;
    // rd wr size addr wdata dsp -> read data, next pointer
    dsa_row_t rows [10] = '{
        '{0, 1, DSA_SIZE_WORD, 16'h0800, 16'h1234, 0, 16'h0000, 16'h0802},
        '{1, 0, DSA_SIZE_BYTE, 16'h0801, 16'h0000, 0, 16'h0012, 16'h0802},
        '{1, 0, DSA_SIZE_BYTE, 16'h0800, 16'h0000, 0, 16'h0034, 16'h0801},
        '{0, 1, DSA_SIZE_BYTE, 16'h0801, 16'h00ab, 0, 16'h0034, 16'h0802},
        '{1, 0, DSA_SIZE_WORD, 16'h0801, 16'h0000, 0, 16'hab34, 16'h0803},
        '{1, 0, DSA_SIZE_BYTE, 16'h0801, 16'h0000, 1, 16'h00ab, 16'h0803},
        '{1, 0, DSA_SIZE_WORD, 16'h0000, 16'h0000, 0, 16'h0000, 16'h0002},
        '{0, 1, DSA_SIZE_WORD, 16'h27fe, 16'h5a5a, 0, 16'h0000, 16'h2800},
        '{1, 0, DSA_SIZE_WORD, 16'h27fe, 16'h0000, 0, 16'h5a5a, 16'h2800},
        '{1, 0, DSA_SIZE_WORD, 16'h2800, 16'h0000, 0, 16'h0000, 16'h2802}};
    dsa_core_model core (.sys_clk, .x_rd, .x_wr, .x_size, .x_addr, .x_wdata, .x_postinc,
                         .x_dsp, .y_rd, .y_addr, .mac_op, .x_mac_ptr, .y_mac_ptr);
    dsa_access uut (.sys_clk, .rstn, .x_rd, .x_wr, .x_size, .x_addr, .x_wdata, .x_postinc,
                    .x_dsp, .x_rdata, .x_next_ptr, .y_rd, .y_addr, .mac_op, .x_mac_ptr,
                    .y_mac_ptr, .y_rdata);
    // counts, verdict and end of run
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // free-running 100 MHz clock
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    // hang guard, far above the few dozen cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 500) begin
            n_mismatch++;
            give_verdict();
        end
    end
    // request, then an idle cycle so the answer has landed when checked
    initial begin
        dsa_ptr_t pc;
        rstn = 0;
        repeat (5) @(posedge sys_clk);
        #1 rstn = 1;
        `CHK("x_next_ptr", 16'h0000, x_next_ptr)
        `CHK("x_rdata", 16'h0000, x_rdata)
        `CHK("y_rdata", 16'h0000, y_rdata)
        foreach (rows[i]) begin
            core.op(rows[i].rd, rows[i].wr, rows[i].sz, rows[i].a, rows[i].d, 1, rows[i].dsp,
                    0, 0, 0, DSA_PTR_X_A, DSA_PTR_Y_A);
            core.op(0, 0, DSA_SIZE_WORD, 0, 0, 0, 0, 0, 0, 0, DSA_PTR_X_A, DSA_PTR_Y_A);
            `CHK("x_rdata", rows[i].er, x_rdata)
            `CHK("x_next_ptr", rows[i].ep, x_next_ptr)
            $display("row %0d done", i);
        end
        // every pointer code on both paths, y at an odd address
        for (int p = 0; p < 4; p++) begin
            pc = dsa_ptr_t'(p);
            core.op(1, 0, DSA_SIZE_WORD, 16'h0800, 0, 0, 0, 1, 16'h0801, 1, pc, pc);
            core.op(0, 0, DSA_SIZE_WORD, 0, 0, 0, 0, 0, 0, 0, DSA_PTR_X_A, DSA_PTR_Y_A);
            `CHK("x_rdata", pc[1] ? 16'h0000 : 16'hab34, x_rdata)
            `CHK("y_rdata", pc[1] ? 16'hab34 : 16'h0000, y_rdata)
        end
        $display("mac test done");
        // crossed codes are harmless outside a mac fetch; y ignores the lsb
        core.op(1, 0, DSA_SIZE_WORD, 16'h0800, 0, 0, 0, 1, 16'h27ff, 0, DSA_PTR_Y_A, DSA_PTR_X_B);
        core.op(0, 0, DSA_SIZE_WORD, 0, 0, 0, 0, 1, 16'h2800, 0, DSA_PTR_X_A, DSA_PTR_Y_A);
        `CHK("x_rdata", 16'hab34, x_rdata)
        `CHK("y_rdata", 16'h5a5a, y_rdata)
        core.op(0, 0, DSA_SIZE_WORD, 0, 0, 0, 0, 0, 0, 0, DSA_PTR_X_A, DSA_PTR_Y_A);
        `CHK("y_rdata", 16'h0000, y_rdata)
        $display("plain fetch test done");
        // reset in mid-run clears the answers at once
        rstn = 0;
        #2 `CHK("y_rdata", 16'h0000, y_rdata)
        `CHK("x_next_ptr", 16'h0000, x_next_ptr)
        `CHK("x_rdata", 16'h0000, x_rdata)
        @(posedge sys_clk);
        #1 rstn = 1;
        // words survive reset; first request right after release
        core.op(1, 0, DSA_SIZE_WORD, 16'h0800, 0, 0, 0, 0, 0, 0, DSA_PTR_X_A, DSA_PTR_Y_A);
        core.op(0, 0, DSA_SIZE_WORD, 0, 0, 0, 0, 0, 0, 0, DSA_PTR_X_A, DSA_PTR_Y_A);
        `CHK("x_rdata", 16'hab34, x_rdata)
        `CHK("y_rdata", 16'h0000, y_rdata)
        $display("reset test done");
        give_verdict();
    end
endmodule : data_space_byte_word_access_bench

//--- bench/dsa_core_model.sv
// core-side model: address generators driving x and y datapath requests
`timescale 1ns/1ps
module dsa_core_model
    import dsa_pkg::*;
(
    input  wire logic   sys_clk,    // core clock
    output logic        x_rd,       // x read
    output logic        x_wr,       // x write
    output dsa_size_t   x_size,     // operand size
    output logic [15:0] x_addr,     // x address
    output logic [15:0] x_wdata,    // write data
    output logic        x_postinc,  // pointer step
    output logic        x_dsp,      // dsp scaling
    output logic        y_rd,       // y read
    output logic [15:0] y_addr,     // y address
    output logic        mac_op,     // mac fetch
    output dsa_ptr_t    x_mac_ptr,  // x pointer code
    output dsa_ptr_t    y_mac_ptr   // y pointer code
);
    // set every request line together
    task put(input logic r, w, dsa_size_t s, logic [15:0] a, d, logic p, q, yr,
             logic [15:0] ya, logic m, dsa_ptr_t xp, yp);
        {x_rd, x_wr, x_postinc, x_dsp, y_rd, mac_op} = {r, w, p, q, yr, m};
        {x_addr, x_wdata, y_addr} = {a, d, ya};
        x_size = s;
        x_mac_ptr = xp;
        y_mac_ptr = yp;
    endtask : put
    // one request, launched just after an edge and held one cycle
    task op(input logic r, w, dsa_size_t s, logic [15:0] a, d, logic p, q, yr,
            logic [15:0] ya, logic m, dsa_ptr_t xp, yp);
        @(posedge sys_clk);
        #1 put(r, w, s, a, d, p, q, yr, ya, m, xp, yp);
    endtask : op
    // quiet bus from time zero
    initial put(0, 0, DSA_SIZE_WORD, 0, 0, 0, 0, 0, 0, 0, DSA_PTR_X_A, DSA_PTR_Y_A);
endmodule : dsa_core_model

//--- hdl/dsa_access.sv
// data space access unit: byte lanes, read select, pointer scaling
`timescale 1ns/1ps
`include "dsa_map.svh"
module dsa_access
    import dsa_pkg::*;
#(
    parameter int RAM_WORDS = `DSA_RAM_WORDS,  // implemented words
    parameter logic [15:0] RAM_BASE = `DSA_RAM_BASE  // first byte address
) (
    input  wire logic             sys_clk,      // core clock
    input  wire logic             rstn,         // async reset, active low
    input  wire logic             x_rd,         // x datapath read request
    input  wire logic             x_wr,         // x datapath write request
    input  wire dsa_size_t        x_size,       // x operand size
    input  wire logic [15:0]      x_addr,       // x effective_address
    input  wire logic [15:0]      x_wdata,      // x write data
    input  wire logic             x_postinc,    // post-increment the pointer
    input  wire logic             x_dsp,        // dsp operation, word scaled
    output logic [15:0]           x_rdata,      // x read data
    output logic [15:0]           x_next_ptr,   // updated source_pointer_reg
    input  wire logic             y_rd,         // y datapath read request
    input  wire logic [15:0]      y_addr,       // y effective_address
    input  wire logic             mac_op,       // access is a mac fetch
    input  wire dsa_ptr_t         x_mac_ptr,    // pointer used on x path
    input  wire dsa_ptr_t         y_mac_ptr,    // pointer used on y path
    output logic [15:0]           y_rdata       // y read data
);
    // ************************************************************
    // elaboration checks
    // ************************************************************
    // refuse a window the word decode cannot serve
    if (RAM_WORDS < 1 || RAM_WORDS > `DSA_SPACE_WORDS) begin : g_bad_words
        $error("dsa_access: RAM_WORDS out of range");
    end
    // an odd base would split words across two decode entries
    if (RAM_BASE[0]) begin : g_bad_base
        $error("dsa_access: RAM_BASE must be even");
    end
    localparam int IW = (RAM_WORDS > 1) ? $clog2(RAM_WORDS) : 1;  // word index width
    localparam logic [16:0] RAM_END = 17'(RAM_BASE) + 17'(2 * RAM_WORDS);  // first byte past
    // the window must end inside the 16-bit byte address space
    if (RAM_END > `DSA_SPACE_END) begin : g_bad_end
        $error("dsa_access: memory window runs past the address space");
    end

    // ************************************************************
    // address decode
    // ************************************************************
    logic [7:0]    lane_lo [RAM_WORDS];     // low byte lane
    logic [7:0]    lane_hi [RAM_WORDS];     // high byte lane
    logic          x_hit;                   // x address implemented
    logic          y_hit;                   // y address implemented
    logic [IW-1:0] x_idx;                   // shared word decode, x
    logic [IW-1:0] y_idx;                   // shared word decode, y
    logic [15:0]   x_off;                   // byte offset, x
    logic [15:0]   y_off;                   // byte offset, y
    logic          x_bad_ptr;               // y pointer into x space
    logic          y_bad_ptr;               // x pointer into y space
    logic          wr_lo;                   // low lane strobe
    logic          wr_hi;                   // high lane strobe

    // byte addresses; word index drops the lsb
    assign x_off = x_addr - RAM_BASE;
    assign y_off = y_addr - RAM_BASE;
    assign x_hit = ({1'b0, x_addr} >= 17'(RAM_BASE)) && ({1'b0, x_addr} < RAM_END);
    assign y_hit = ({1'b0, y_addr} >= 17'(RAM_BASE)) && ({1'b0, y_addr} < RAM_END);
    assign x_idx = IW'(x_off[15:1]);
    assign y_idx = IW'(y_off[15:1]);
    assign x_bad_ptr = mac_op && (x_mac_ptr == DSA_PTR_Y_A || x_mac_ptr == DSA_PTR_Y_B);
    assign y_bad_ptr = mac_op && (y_mac_ptr == DSA_PTR_X_A || y_mac_ptr == DSA_PTR_X_B);

    // lane strobes: byte writes hit one lane, word writes both
    assign wr_lo = x_wr && x_hit && (x_size == DSA_SIZE_WORD || !x_addr[0]);
    assign wr_hi = x_wr && x_hit && (x_size == DSA_SIZE_WORD || x_addr[0]);

    // ************************************************************
    // byte lane storage
    // ************************************************************
    // each lane has its own write line on the shared decode
    always_ff @(posedge sys_clk) begin
        if (wr_lo) begin
            lane_lo[x_idx] <= x_wdata[7:0];
        end
        if (wr_hi) begin
            lane_hi[x_idx] <= (x_size == DSA_SIZE_BYTE) ? x_wdata[7:0] : x_wdata[15:8];
        end
    end

    // ************************************************************
    // read paths
    // ************************************************************
    // x read: whole word fetched, byte placed on low lane
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            x_rdata <= `DSA_ZERO_WORD;
        end else if (x_rd) begin
            if (!x_hit || x_bad_ptr) begin
                x_rdata <= `DSA_ZERO_WORD;
            end else if (x_size == DSA_SIZE_BYTE) begin
                x_rdata <= {8'h00, x_addr[0] ? lane_hi[x_idx] : lane_lo[x_idx]};
            end else begin
                x_rdata <= {lane_hi[x_idx], lane_lo[x_idx]};
            end
        end
    end

    // y read: words only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            y_rdata <= `DSA_ZERO_WORD;
        end else if (y_rd) begin
            if (!y_hit || y_bad_ptr) begin
                y_rdata <= `DSA_ZERO_WORD;
            end else begin
                y_rdata <= {lane_hi[y_idx], lane_lo[y_idx]};
            end
        end
    end

    // ************************************************************
    // pointer post-modification
    // ************************************************************
    // step scaled by size; dsp operations always step words
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            x_next_ptr <= `DSA_ZERO_WORD;
        end else if (x_postinc) begin
            if (x_dsp || x_size == DSA_SIZE_WORD) begin
                x_next_ptr <= x_addr + `DSA_STEP_WORD;
            end else begin
                x_next_ptr <= x_addr + `DSA_STEP_BYTE;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    // zero answers for holes and for crossed mac pointers
    unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_rd && !x_hit |=> x_rdata == 16'h0000)
        else $error("unmapped x read not zero");
    y_unmapped_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        y_rd && !y_hit |=> y_rdata == `DSA_ZERO_WORD)
        else $error("unmapped y read not zero");
    x_ptr_y_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        y_rd && y_bad_ptr |=> y_rdata == 16'h0000)
        else $error("x pointer into y space not zero");
    y_ptr_x_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_rd && x_bad_ptr |=> x_rdata == 16'h0000)
        else $error("y pointer into x space not zero");

    // ************************************************************
    // read data checks
    // ************************************************************
    // a byte read carries the addressed lane alone, high byte zero
    byte_read_hi_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_rd && x_size == DSA_SIZE_BYTE |=> x_rdata[15:8] == 8'h00)
        else $error("byte read high lane not zero");
    byte_read_sel_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_rd && x_hit && !x_bad_ptr && x_size == DSA_SIZE_BYTE
        |=> x_rdata[7:0]
            == ($past(x_addr[0]) ? $past(lane_hi[x_idx]) : $past(lane_lo[x_idx])))
        else $error("byte read took the wrong lane");
    // word reads on either path join both lanes of one word
    x_word_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_rd && x_hit && !x_bad_ptr && x_size == DSA_SIZE_WORD
        |=> x_rdata == {$past(lane_hi[x_idx]), $past(lane_lo[x_idx])})
        else $error("x word read not both lanes");
    y_word_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        y_rd && y_hit && !y_bad_ptr
        |=> y_rdata == {$past(lane_hi[y_idx]), $past(lane_lo[y_idx])})
        else $error("y word read not both lanes");

    // ************************************************************
    // write lane checks
    // ************************************************************
    // a byte write lands in the lane of its address
    lane_strobe_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_wr && x_hit && x_size == DSA_SIZE_BYTE
        |=> ($past(x_addr[0]) ? lane_hi[$past(x_idx)] : lane_lo[$past(x_idx)])
            == $past(x_wdata[7:0]))
        else $error("byte write missed its lane");
    // and leaves the other lane of that word as it was
    byte_lane_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_wr && x_hit && x_size == DSA_SIZE_BYTE
        |=> ($past(x_addr[0]) ? lane_lo[$past(x_idx)] : lane_hi[$past(x_idx)])
            == ($past(x_addr[0]) ? $past(lane_lo[x_idx]) : $past(lane_hi[x_idx])))
        else $error("byte write disturbed the other lane");
    // a word write fills both lanes of the word
    word_strobe_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_wr && x_hit && x_size == DSA_SIZE_WORD
        |=> {lane_hi[$past(x_idx)], lane_lo[$past(x_idx)]} == $past(x_wdata))
        else $error("word write missed a lane");

    // ************************************************************
    // pointer checks
    // ************************************************************
    // post-increment steps by operand size, dsp always by a word
    byte_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_postinc && !x_dsp && x_size == DSA_SIZE_BYTE
        |=> x_next_ptr == $past(x_addr) + 16'h0001)
        else $error("byte post-increment wrong");
    word_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_postinc && !x_dsp && x_size == DSA_SIZE_WORD
        |=> x_next_ptr == $past(x_addr) + `DSA_STEP_WORD)
        else $error("word post-increment wrong");
    dsp_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_postinc && x_dsp |=> x_next_ptr == $past(x_addr) + 16'h0002)
        else $error("dsp post-increment wrong");
    dsp_align_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        x_postinc && x_dsp |=> x_next_ptr[0] == $past(x_addr[0]))
        else $error("dsp step broke word alignment");
endmodule : dsa_access

//--- hdl/dsa_map.svh
// constants for the data space byte/word access unit
`ifndef DSA_MAP_SVH
`define DSA_MAP_SVH
`define DSA_ADDR_W      16
`define DSA_DATA_W      16
`define DSA_ZERO_WORD   16'h0000
`define DSA_STEP_BYTE   16'h0001
`define DSA_STEP_WORD   16'h0002
`define DSA_RAM_WORDS   4096
`define DSA_RAM_BASE    16'h0800
`define DSA_SPACE_WORDS 32768
`define DSA_SPACE_END   17'h10000
`endif

//--- hdl/dsa_pkg.sv
// types for the data space byte/word access unit
package dsa_pkg;
    // operand size of an access
    typedef enum logic {
        DSA_SIZE_WORD = 1'b0,
        DSA_SIZE_BYTE = 1'b1
    } dsa_size_t;
    // pointer register used by a multiply-accumulate fetch
    typedef enum logic [1:0] {
        DSA_PTR_X_A = 2'b00,
        DSA_PTR_X_B = 2'b01,
        DSA_PTR_Y_A = 2'b11,
        DSA_PTR_Y_B = 2'b10
    } dsa_ptr_t;
endpackage : dsa_pkg
